// ===== pkg/teach_step_pkg.sv
package teach_step_pkg;

	// Teach table
	localparam int          ENTRY_COUNT   = 100;
	localparam int          IDX_W         = 7;
	localparam logic [6:0]  LAST_ENTRY    = 7'h63;
	localparam int          POS_W         = 32;
	localparam int          VEL_W         = 16;
	localparam int          IN_W          = 3;

	// Servo tick timing
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          TICK_US       = 1000;
	localparam int          TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;

	// Pulse counting and scaling
	localparam int          PCNT_W        = 16;
	localparam int          SCALE_W       = 16;
	localparam logic [15:0] SCALE_RESET   = 16'h0001;

	// Reset values
	localparam logic [31:0] POS_RESET     = 32'h0000_0000;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT,
		SEQ_MOVE
	} seq_state_type;

	// One taught entry: target, velocity, match pattern (care mask and levels)
	typedef struct packed {
		logic [POS_W-1:0] target;
		logic [VEL_W-1:0] velocity;
		logic [IN_W-1:0]  care;
		logic [IN_W-1:0]  level;
	} entry_type;

	// Move request to the trajectory generator
	typedef struct packed {
		logic             start;
		logic             absolute;
		logic [POS_W-1:0] target;
		logic [VEL_W-1:0] velocity;
	} move_cmd_type;

	// Step-input command toward the servo loop
	typedef struct packed {
		logic             valid;
		logic [POS_W-1:0] increment;
		logic [POS_W-1:0] position;
	} step_cmd_type;

	typedef struct packed {
		seq_state_type      seq;
		logic [IDX_W-1:0]   index;
		logic               absolute;
		move_cmd_type       move;
		logic               step_prev;
		logic signed [PCNT_W-1:0] pcount;
		logic [31:0]        tick_cnt;
		step_cmd_type       cmd;
	} state_type;

endpackage

// ===== hdl/teach_and_step_dir_position_cmd.sv
// Function
// - Hold up to 100 taught entries of target, velocity and match pattern.
// - Each input is must-be-high, must-be-low or ignored in matching.
// - Matching inputs start a move to the entry's position and velocity.
// - Entries run strictly in ascending order, 0 through teach_count - 1 (at most 99), never skipped.
// - Starting the taught sequence switches the reference to absolute mode.
// - Each servo tick captures pulses since last tick as the increment.
// - By default one step pulse equals one encoder count.
// - Captured pulse count is multiplied by a configurable scale factor.
// - Scale factor comes from a dedicated multiplier configuration input.
`timescale 1ns/1ps
module teach_and_step_dir_position_cmd
	import teach_step_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 reset,
	// Teach table write port
	input  wire logic                 teach_we,
	input  wire logic [IDX_W-1:0]     teach_addr,
	input  wire entry_type            teach_data,
	input  wire logic [IDX_W-1:0]     teach_count,
	// Sequencer control
	input  wire logic                 run_start,
	input  wire logic                 run_stop,
	input  wire logic                 move_done,
	input  wire logic [IN_W-1:0]      dig_in,
	output logic                      seq_busy,
	output logic [IDX_W-1:0]          seq_index,
	output logic                      abs_mode,
	output move_cmd_type              move_cmd,
	// Step and direction input
	input  wire logic                 step_in,
	input  wire logic                 dir_in,
	input  wire logic [SCALE_W-1:0]   step_multiplier,
	output step_cmd_type              step_cmd
);

	entry_type entries_r [ENTRY_COUNT];
	state_type state_r;
	state_type state_nxt;
	entry_type cur_entry;
	logic      match;
	logic      step_edge;
	logic      tick;
	logic signed [PCNT_W+SCALE_W:0] scaled;
	logic [IDX_W-1:0] last_idx;
	logic [IN_W-1:0]  bit_ok;
	logic [SCALE_W-1:0] scale_eff;

	// Table is not cleared by reset; entries hold whatever was taught last
	// table storage
	always_ff @(posedge mclk)
	begin
		if (teach_we && teach_addr <= LAST_ENTRY)
		begin
			entries_r[teach_addr] <= teach_data;
		end
	end

	assign cur_entry = entries_r[state_r.index];
	// per-input compare, an ignored input always agrees
	generate
		for (genvar b = 0; b < IN_W; b++)
		begin : g_match
			assign bit_ok[b] = !cur_entry.care[b] || (dig_in[b] == cur_entry.level[b]);
		end
	endgenerate
	assign match     = &bit_ok;

	// last entry from the taught count, capped at the table size
	always_comb
	begin
		if (teach_count == '0)
		begin
			last_idx = '0;
		end
		else if (teach_count > LAST_ENTRY)
		begin
			last_idx = LAST_ENTRY;
		end
		else
		begin
			last_idx = teach_count - 7'h01;
		end
	end

	assign step_edge = step_in && !state_r.step_prev;
	// Tick period is a parameter so simulation can run short windows
	assign tick      = state_r.tick_cnt >= 32'(TICK_LEN - 1);
	// a factor of zero falls back to one count per pulse
	assign scale_eff = (step_multiplier == '0) ? SCALE_RESET : step_multiplier;
	assign scaled    = $signed(state_r.pcount) * $signed({1'b0, scale_eff});

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.move.start = 1'b0;
		state_nxt.cmd.valid  = 1'b0;
		state_nxt.step_prev  = step_in;
		case (state_r.seq)
			SEQ_IDLE:
			begin
				if (run_start && teach_count != '0)
				begin
					state_nxt.absolute = 1'b1;
					state_nxt.index    = '0;
					state_nxt.seq      = SEQ_WAIT;
				end
			end
			SEQ_WAIT:
			begin
				if (match)
				begin
					state_nxt.move.start    = 1'b1;
					state_nxt.move.absolute = 1'b1;
					state_nxt.move.target   = cur_entry.target;
					state_nxt.move.velocity = cur_entry.velocity;
					state_nxt.seq           = SEQ_MOVE;
				end
			end
			SEQ_MOVE:
			begin
				// Inputs are ignored while a move runs
				if (move_done)
				begin
					if (state_r.index >= last_idx)
					begin
						state_nxt.seq = SEQ_IDLE;
					end
					else
					begin
						state_nxt.index = state_r.index + 7'd1;
						state_nxt.seq   = SEQ_WAIT;
					end
				end
			end
			default:
			begin
				state_nxt.seq = SEQ_IDLE;
			end
		endcase
		// Abort wins, and also cancels a start decided in this cycle
		if (run_stop)
		begin
			state_nxt.seq        = SEQ_IDLE;
			state_nxt.move.start = 1'b0;
		end

		if (tick)
		begin
			state_nxt.tick_cnt = '0;
		end
		else
		begin
			state_nxt.tick_cnt = state_r.tick_cnt + 32'd1;
		end
		if (tick)
		begin
			// Pulse landing on the tick edge is carried into the next window
			if (step_edge)
			begin
				state_nxt.pcount = dir_in ? 16'sh0001 : -16'sh0001;
			end
			else
			begin
				state_nxt.pcount = '0;
			end
			state_nxt.cmd.increment = POS_W'(scaled);
			state_nxt.cmd.position  = state_r.cmd.position + POS_W'(scaled);
			state_nxt.cmd.valid     = 1'b1;
		end
		else if (step_edge)
		begin
			// Net count wraps if one window sees more than 32767 pulses
			// direction picks sign
			if (dir_in)
			begin
				state_nxt.pcount = state_r.pcount + 16'sd1;
			end
			else
			begin
				state_nxt.pcount = state_r.pcount - 16'sd1;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= '0;
			state_r.seq <= SEQ_IDLE;
			state_r.cmd.position <= POS_RESET;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign seq_busy  = state_r.seq != SEQ_IDLE;
	assign seq_index = state_r.index;
	assign abs_mode  = state_r.absolute;
	assign move_cmd  = state_r.move;
	assign step_cmd  = state_r.cmd;

endmodule

// ===== tb/teach_step_chk.sv
`timescale 1ns/1ps
module teach_step_chk
	import teach_step_pkg::*;
#(
	parameter int TICK_LEN = 20
)
(
	// Clock and reset
	input wire logic		mclk,
	input wire logic		reset,
	// Watched
	input wire logic		run_start,
	input wire logic		run_stop,
	input wire logic [IDX_W-1:0]	teach_count,
	input wire logic		seq_busy,
	input wire logic [IDX_W-1:0]	seq_index,
	input wire logic		abs_mode,
	input wire move_cmd_type	move_cmd,
	input wire step_cmd_type	step_cmd
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_go;
		!seq_busy && run_start && !run_stop && teach_count != 7'h0;
	endsequence
	go_busy_a: assert property (s_go |=> seq_busy && seq_index == 7'h0)
		else $error("start not taken");
	abs_set_a: assert property (s_go |=> abs_mode)
		else $error("absolute not set");
	abs_hold_a: assert property (abs_mode |=> abs_mode)
		else $error("absolute dropped");
	start_once_a: assert property (move_cmd.start |=> !move_cmd.start)
		else $error("start too long");
	start_abs_a: assert property (move_cmd.start |-> move_cmd.absolute && seq_busy)
		else $error("move not absolute");
	idx_step_a: assert property (seq_busy && $past(seq_busy) && $changed(seq_index)
		|-> seq_index == $past(seq_index) + 7'h1)
		else $error("index jumped");
	tick_gap_a: assert property (step_cmd.valid |=> !step_cmd.valid [*8])
		else $error("tick too soon");
	tick_per_a: assert property (step_cmd.valid |-> ##TICK_LEN step_cmd.valid)
		else $error("tick missing");
	pos_acc_a: assert property (step_cmd.valid
		|-> step_cmd.position == $past(step_cmd.position) + step_cmd.increment)
		else $error("position wrong");
	pos_hold_a: assert property (!step_cmd.valid |-> $stable(step_cmd.position))
		else $error("position moved");
endmodule
bind teach_and_step_dir_position_cmd teach_step_chk #(.TICK_LEN(TICK_LEN)) u_teach_step_chk (
	.mclk, .reset, .run_start, .run_stop, .teach_count, .seq_busy, .seq_index,
	.abs_mode, .move_cmd, .step_cmd);

// ===== tb/step_dir_src.sv
`timescale 1ns/1ps
module step_dir_src
(
	// Clock and control
	input wire logic	mclk,
	input wire logic	go,
	input wire logic	up,
	input wire logic [7:0]	n,
	input wire logic [3:0]	gap,
	// Pins
	output logic		step_in,
	output logic		dir_in,
	output logic		busy
);
	initial
	begin
		{step_in, dir_in, busy} = 3'h0;
	end
	always @(posedge go)
	begin
		busy = 1;
		dir_in = up;
		repeat (n)
		begin
			step_in = 1;
			repeat (gap) @(negedge mclk);
			step_in = 0;
			repeat (gap) @(negedge mclk);
		end
		busy = 0;
	end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	import teach_step_pkg::*;
	logic			mclk, reset, teach_we, run_start, run_stop, move_done;
	logic			go, up, sbusy, step_in, dir_in, seq_busy, abs_mode;
	logic [IDX_W-1:0]	teach_addr, teach_count, seq_index;
	logic [IN_W-1:0]	dig_in;
	logic [IN_W-1:0]	mt [3];
	logic [15:0]		mult;
	logic [7:0]		n;
	logic [3:0]		gap;
	entry_type		teach_data;
	entry_type		ent [3];
	move_cmd_type		move_cmd;
	step_cmd_type		step_cmd;
	int			fails, checks_done, cyc, e;
	teach_and_step_dir_position_cmd #(.TICK_LEN(20)) u_teach_and_step_dir_position_cmd (
		.mclk, .reset, .teach_we, .teach_addr, .teach_data, .teach_count, .run_start,
		.run_stop, .move_done, .dig_in, .seq_busy, .seq_index, .abs_mode, .move_cmd,
		.step_in, .dir_in, .step_multiplier(mult), .step_cmd);
	step_dir_src u_step_dir_src (.mclk, .go, .up, .n, .gap, .step_in, .dir_in, .busy(sbusy));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bounded wait for valid (1) or start (0)
	task wait_ev(input logic sel);
		repeat (100)
		begin
			@(posedge mclk);
			#1;
			if (sel ? step_cmd.valid : move_cmd.start)
				break;
		end
		chk(32'(sel ? step_cmd.valid : move_cmd.start), 32'h1);
	endtask
	task t_step(input logic u, input logic [7:0] k, input logic [3:0] g, input logic [15:0] m);
		int		d;
		logic [31:0]	inc;
		d = (u ? 1 : -1) * int'(k) * ((m == 16'h0000) ? 1 : int'(m));
		@(negedge mclk);
		{up, n, gap, mult, go} = {u, k, g, m, 1'b1};
		@(negedge mclk);
		go = 0;
		repeat (300) if (sbusy) @(negedge mclk);
		wait_ev(1);
		inc = step_cmd.increment;
		wait_ev(1);
		inc += step_cmd.increment;
		e += d;
		chk(inc, 32'(d));
		chk(step_cmd.position, 32'(e));
		$display("test step done");
	endtask
	task t_teach;
		for (int i = 0; i < 3; i++)
		begin
			@(negedge mclk);
			{teach_we, teach_addr, teach_data} = {1'b1, 7'(i), ent[i]};
		end
		@(negedge mclk);
		{teach_we, teach_count, run_start, dig_in} = {1'b0, 7'h3, 1'b1, 3'h4};
		chk(32'(abs_mode), 32'h0);
		@(negedge mclk);
		run_start = 0;
		repeat (5) @(negedge mclk);
		chk(move_cmd.target, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			dig_in = mt[i];
			wait_ev(0);
			chk(move_cmd.target, ent[i].target);
			chk(32'(move_cmd.velocity), 32'(ent[i].velocity));
			chk(32'({abs_mode, move_cmd.absolute, seq_index}), 32'({2'h3, 7'(i)}));
			@(negedge mclk);
			move_done = 1;
			@(negedge mclk);
			move_done = 0;
		end
		repeat (4) @(negedge mclk);
		chk(32'(seq_busy), 32'h0);
		$display("test teach done");
	endtask
	task t_abort;
		@(negedge mclk);
		{run_start, dig_in} = {1'b1, 3'h4};
		@(negedge mclk);
		run_start = 0;
		chk(32'({abs_mode, seq_busy, seq_index}), 32'({2'h3, 7'h00}));
		dig_in = mt[0];
		wait_ev(0);
		chk(move_cmd.target, ent[0].target);
		@(negedge mclk);
		run_stop = 1;
		@(negedge mclk);
		run_stop = 0;
		move_done = 1;
		@(negedge mclk);
		move_done = 0;
		repeat (3) @(negedge mclk);
		chk(32'({seq_busy, move_cmd.start, seq_index}), 32'h0);
		$display("test abort done");
	endtask
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			close_out;
		end
	end
	initial
	begin
		{reset, teach_we, run_start, run_stop, move_done, go, up} = 7'h41;
		{teach_addr, teach_count, dig_in, n, gap, mult, e} = '0;
		teach_data = '0;
		ent[0] = '{32'h0001_0000, 16'h0010, 3'h5, 3'h1};
		ent[1] = '{32'hffff_ff00, 16'h0200, 3'h0, 3'h7};
		ent[2] = '{32'h0000_0abc, 16'h0033, 3'h7, 3'h6};
		mt = '{3'h3, 3'h3, 3'h6};
		repeat (20) @(negedge mclk);
		reset = 0;
		t_step(1, 8'h05, 4'h1, 16'h0001);
		t_step(1, 8'h05, 4'h1, 16'h0003);
		t_step(0, 8'h04, 4'h2, 16'h0003);
		t_step(1, 8'h03, 4'h1, 16'h0000);
		t_teach;
		t_abort;
		close_out;
	end
endmodule
